// ### design/hsc_consts.svh
`ifndef HSC_CONSTS_SVH
`define HSC_CONSTS_SVH
`define HSC_ADDR_CTRL 8'h00
`define HSC_ADDR_STATUS 8'h04
`define HSC_ADDR_FREQ 8'h08
`define HSC_ADDR_OFFSET 8'h0C
`define HSC_ADDR_KEY 8'h10
`define HSC_ADDR_WIDTH 8'h14
`define HSC_ADDR_DWELL 8'h18
`define HSC_ADDR_STEP 8'h1C
`define HSC_ADDR_SPTR 8'h20
`define HSC_ADDR_SDATA 8'h24
`define HSC_RST_CTRL 3'h0
`define HSC_RST_FREQ 24'h000000
`define HSC_RST_OFFSET 8'h00
`define HSC_RST_KEY 16'h0000
`define HSC_RST_WIDTH 8'h00
`define HSC_RST_DWELL 8'h00
`define HSC_RST_STEP 16'h0000
`define HSC_SCRIPT_MAX 120
`define HSC_MAX_ARGS 6
`define HSC_CLK_NS 10
`define HSC_DWELL_UNIT_NS 83333
`define HSC_DWELL_UNIT_CYC (`HSC_DWELL_UNIT_NS / `HSC_CLK_NS)
`define HSC_CH_CR 8'h0D
`define HSC_CH_LF 8'h0A
`define HSC_CH_SP 8'h20
`define HSC_CH_TILDE 8'h7E
`define HSC_CH_QM 8'h3F
`endif

// ### design/hsc_pkg.sv
package hsc_pkg;
  typedef enum logic [1:0] {
    HSC_IDLE = 2'b00,
    HSC_ARGS = 2'b01,
    HSC_LOAD = 2'b10
  } hsc_state_e;
  typedef enum logic [2:0] {
    HSC_RSP_NONE = 3'b000,
    HSC_RSP_QM = 3'b001,
    HSC_RSP_ACK = 3'b010,
    HSC_RSP_HELP = 3'b011,
    HSC_RSP_RPT = 3'b100,
    HSC_RSP_BOOT = 3'b101
  } hsc_resp_e;
endpackage

// ### design/hsc_symclk.sv
`timescale 1ns/1ps
`include "hsc_consts.svh"
module hsc_symclk (
  input wire logic clock,
  input wire logic rst,
  input wire logic sym_pin,
  input wire logic [15:0] periods,
  output logic tick_o
);
  logic s1_q, s2_q, s3_q, lvl_q;
  logic [15:0] cnt_q;
  wire agree_w = s2_q == s3_q;
  wire rise_w = agree_w && s3_q && !lvl_q;
  wire wrap_w = cnt_q >= periods;
  always_ff @(posedge clock) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
      cnt_q <= 16'h0000;
      tick_o <= 1'b0;
    end else begin
      s1_q <= sym_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (agree_w) lvl_q <= s3_q;
      tick_o <= rise_w && wrap_w;
      // symbol lasts periods+1 pin periods
      if (rise_w) cnt_q <= wrap_w ? 16'h0000 : cnt_q + 16'h0001;
    end
  end
  sym_period_a: assert property (@(posedge clock) disable iff (rst)
    tick_o |-> $past(cnt_q) >= $past(periods) && cnt_q == 16'h0000)
    else $error("symbol tick before period count reached");
endmodule

// ### design/hsc_sweep.sv
`timescale 1ns/1ps
`include "hsc_consts.svh"
module hsc_sweep #(
  parameter int UNIT_CYC = `HSC_DWELL_UNIT_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic en,
  input wire logic [23:0] base,
  input wire logic [15:0] step,
  input wire logic [7:0] dwell,
  input wire logic [7:0] width,
  output logic [23:0] freq_o,
  output logic sync_o
);
  logic [15:0] cyc_q;
  logic [7:0] units_q, idx_q;
  wire unit_end_w = cyc_q == 16'(UNIT_CYC - 1);
  wire dwell_end_w = unit_end_w && (dwell == 8'h00 || units_q == dwell - 8'h01);
  always_ff @(posedge clock) begin
    if (rst || !en) begin
      cyc_q <= 16'h0000;
      units_q <= 8'h00;
      idx_q <= 8'h00;
      freq_o <= base;
      sync_o <= 1'b0;
    end else begin
      cyc_q <= unit_end_w ? 16'h0000 : cyc_q + 16'h0001;
      sync_o <= 1'b0;
      if (dwell_end_w) begin
        units_q <= 8'h00;
        if (idx_q >= width - 8'h01) begin
          idx_q <= 8'h00;
          freq_o <= base;
          sync_o <= 1'b1;
        end else begin
          idx_q <= idx_q + 8'h01;
          freq_o <= freq_o + {8'h00, step};
        end
      end else if (unit_end_w) begin
        units_q <= units_q + 8'h01;
      end
    end
  end
  sweep_wrap_a: assert property (@(posedge clock) disable iff (rst)
    sync_o |-> freq_o == $past(base))
    else $error("sweep sync without return to base frequency");
endmodule

// ### design/hsc_top.sv
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "hsc_consts.svh"
module hsc_top
  import hsc_pkg::*;
#(
  parameter int DWELL_UNIT_CYC = `HSC_DWELL_UNIT_CYC,
  parameter int SCRIPT_MAX = `HSC_SCRIPT_MAX
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire logic [7:0] rx_char,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_char,
  input wire logic tx_ready,
  input wire logic sym_clk_pin,
  output logic sym_tick,
  output logic [23:0] tune_word,
  output logic carrier_on,
  output logic sweep_sync
);
  localparam logic [183:0] HELP_TXT = {"A2 B F6 H K4 R T W2 X", `HSC_CH_CR, `HSC_CH_LF};
  localparam logic [63:0] BOOT_TXT = {"HSC OK", `HSC_CH_CR, `HSC_CH_LF};

  function automatic logic is_hex(input logic [7:0] c);
    return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66);
  endfunction
  function automatic logic [3:0] hex_val(input logic [7:0] c);
    return (c <= 8'h39) ? c[3:0] : c[3:0] + 4'h9;
  endfunction
  function automatic logic [7:0] hex_ch(input logic [3:0] n);
    return (n < 4'hA) ? {4'h3, n} : 8'h37 + {4'h0, n};
  endfunction
  function automatic logic [2:0] arg_cnt(input logic [7:0] u);
    if (u == 8'h41 || u == 8'h57) return 3'h2;
    else if (u == 8'h46) return 3'h6;
    else if (u == 8'h4B) return 3'h4;
    else return 3'h0;
  endfunction
  function automatic logic known(input logic [7:0] u);
    return u == 8'h41 || u == 8'h42 || u == 8'h46 || u == 8'h48 || u == 8'h4B
        || u == 8'h52 || u == 8'h54 || u == 8'h57 || u == 8'h58;
  endfunction

  hsc_state_e st_q, st_d;
  hsc_resp_e resp_k;
  logic [7:0] cmd_q;
  logic [2:0] need_q, got_q;
  logic [23:0] arg_q;
  logic [23:0] freq_q;
  logic [7:0] offset_q, width_q, dwell_q;
  logic [15:0] key_q, step_q;
  logic key_on_q;
  logic [2:0] mode_q;
  logic [7:0] script_mem [0:SCRIPT_MAX-1];
  logic [6:0] wr_cnt_q, script_len_q, sptr_q;
  logic [3:0] hi_nib_q;
  logic half_q;
  logic [191:0] buf_q;
  logic [4:0] left_q;
  logic resp_active_q, pend_rst_q, boot_q;
  logic exec, save, byte_wr;
  logic [23:0] sweep_freq;
  logic sweep_sync_w;

  // character decode
  wire take_w = rx_valid && rx_ready;
  wire [7:0] uc_w = (rx_char >= 8'h61 && rx_char <= 8'h7A) ? rx_char - 8'h20 : rx_char;
  wire hex_w = is_hex(rx_char);
  wire [3:0] nib_w = hex_val(rx_char);
  wire [23:0] arg_next_w = {arg_q[19:0], nib_w};
  wire [7:0] cmd_x_w = (st_q == HSC_IDLE) ? uc_w : cmd_q;
  wire sweep_w = width_q != 8'h00;
  wire boot_go_w = boot_q && !resp_active_q;
  wire resp_go_w = resp_k != HSC_RSP_NONE;
  wire resp_done_w = tx_valid && tx_ready && left_q == 5'h00;
  wire soft_rst_w = save || (resp_done_w && pend_rst_q);

  always_comb begin
    st_d = st_q;
    resp_k = HSC_RSP_NONE;
    exec = 1'b0;
    save = 1'b0;
    byte_wr = 1'b0;
    if (boot_go_w) begin
      resp_k = HSC_RSP_BOOT;
    end else if (take_w) begin
      case (st_q)
        HSC_IDLE: begin
          if (rx_char == `HSC_CH_LF) begin
            st_d = HSC_IDLE;
          end else if (!known(uc_w)) begin
            resp_k = HSC_RSP_QM;
          end else if (arg_cnt(uc_w) != 3'h0) begin
            st_d = HSC_ARGS;
          end else if (uc_w == 8'h42) begin
            st_d = HSC_LOAD;
            resp_k = HSC_RSP_ACK;
          end else if (uc_w == 8'h48) begin
            resp_k = HSC_RSP_HELP;
          end else if (uc_w == 8'h52) begin
            resp_k = HSC_RSP_RPT;
          end else begin
            exec = 1'b1;
          end
        end
        HSC_ARGS: begin
          if (rx_char == `HSC_CH_LF) begin
            st_d = HSC_ARGS;
          end else if (!hex_w) begin
            st_d = HSC_IDLE;
            resp_k = HSC_RSP_QM;
          end else if (got_q + 3'h1 == need_q) begin
            st_d = HSC_IDLE;
            exec = 1'b1;
            resp_k = HSC_RSP_ACK;
          end
        end
        HSC_LOAD: begin
          if (rx_char == `HSC_CH_CR || rx_char == `HSC_CH_SP) begin
            st_d = HSC_LOAD;
          end else if (hex_w) begin
            byte_wr = half_q;
          end else if (rx_char == `HSC_CH_TILDE) begin
            st_d = HSC_IDLE;
            save = 1'b1;
          end else begin
            st_d = HSC_IDLE;
            resp_k = HSC_RSP_QM;
          end
        end
        default: st_d = HSC_IDLE;
      endcase
    end
  end

  // report line: effective A and K values follow the sweep swap
  wire [7:0] rpt_a_w = sweep_w ? dwell_q : offset_q;
  wire [15:0] rpt_k_w = sweep_w ? step_q : key_q;
  wire [191:0] rpt_w = {8'h41, hex_ch(rpt_a_w[7:4]), hex_ch(rpt_a_w[3:0]),
    `HSC_CH_SP, 8'h4B, hex_ch(rpt_k_w[15:12]), hex_ch(rpt_k_w[11:8]),
    hex_ch(rpt_k_w[7:4]), hex_ch(rpt_k_w[3:0]),
    `HSC_CH_SP, 8'h57, hex_ch(width_q[7:4]), hex_ch(width_q[3:0]),
    `HSC_CH_SP, 8'h46, hex_ch(freq_q[23:20]), hex_ch(freq_q[19:16]), hex_ch(freq_q[15:12]),
    hex_ch(freq_q[11:8]), hex_ch(freq_q[7:4]), hex_ch(freq_q[3:0]),
    `HSC_CH_CR, `HSC_CH_LF, 8'h00};
  wire [191:0] line_w = (resp_k == HSC_RSP_QM) ? {`HSC_CH_QM, `HSC_CH_CR, `HSC_CH_LF, 168'h0} :
    (resp_k == HSC_RSP_ACK) ? {cmd_x_w, `HSC_CH_CR, `HSC_CH_LF, 168'h0} :
    (resp_k == HSC_RSP_HELP) ? {HELP_TXT, 8'h00} :
    (resp_k == HSC_RSP_RPT) ? rpt_w : {BOOT_TXT, 128'h0};
  wire [4:0] len_w = (resp_k == HSC_RSP_HELP || resp_k == HSC_RSP_RPT) ? 5'h17 :
    (resp_k == HSC_RSP_BOOT) ? 5'h08 : 5'h03;

  // parser and parameters
  always_ff @(posedge clock) begin
    if (rst || soft_rst_w) begin
      st_q <= HSC_IDLE;
      cmd_q <= 8'h00;
      need_q <= 3'h0;
      got_q <= 3'h0;
      arg_q <= 24'h000000;
      freq_q <= `HSC_RST_FREQ;
      offset_q <= `HSC_RST_OFFSET;
      key_q <= `HSC_RST_KEY;
      width_q <= `HSC_RST_WIDTH;
      dwell_q <= `HSC_RST_DWELL;
      step_q <= `HSC_RST_STEP;
      key_on_q <= 1'b0;
      wr_cnt_q <= 7'h00;
      hi_nib_q <= 4'h0;
      half_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (take_w && st_q == HSC_IDLE) begin
        cmd_q <= uc_w;
        need_q <= arg_cnt(uc_w);
        got_q <= 3'h0;
        arg_q <= 24'h000000;
        wr_cnt_q <= 7'h00;
        half_q <= 1'b0;
      end else if (take_w && st_q == HSC_ARGS && hex_w) begin
        got_q <= got_q + 3'h1;
        arg_q <= arg_next_w;
      end
      if (take_w && st_q == HSC_LOAD && hex_w) begin
        half_q <= !half_q;
        hi_nib_q <= nib_w;
        if (byte_wr && wr_cnt_q < 7'(SCRIPT_MAX)) wr_cnt_q <= wr_cnt_q + 7'h01;
      end
      if (exec) begin
        case (cmd_x_w)
          8'h41: begin
            if (sweep_w) dwell_q <= arg_next_w[7:0];
            else offset_q <= arg_next_w[7:0];
          end
          8'h46: freq_q <= arg_next_w;
          8'h4B: begin
            if (sweep_w) step_q <= arg_next_w[15:0];
            else key_q <= arg_next_w[15:0];
          end
          8'h57: if (arg_next_w[7:0] != 8'h01) width_q <= arg_next_w[7:0];
          8'h54: key_on_q <= 1'b1;
          8'h58: key_on_q <= 1'b0;
          default: key_on_q <= key_on_q;
        endcase
      end
    end
  end

  // script survives the soft reset that follows a load
  always_ff @(posedge clock) begin
    if (byte_wr && wr_cnt_q < 7'(SCRIPT_MAX)) script_mem[wr_cnt_q] <= {hi_nib_q, nib_w};
  end
  always_ff @(posedge clock) begin
    if (rst) script_len_q <= 7'h00;
    else if (save) script_len_q <= wr_cnt_q;
  end

  // response sender
  always_ff @(posedge clock) begin
    if (rst) begin
      buf_q <= 192'h0;
      left_q <= 5'h00;
      tx_valid <= 1'b0;
      tx_char <= 8'h00;
      resp_active_q <= 1'b0;
      pend_rst_q <= 1'b0;
      boot_q <= 1'b1;
      rx_ready <= 1'b0;
    end else begin
      rx_ready <= !(take_w || resp_go_w || resp_active_q || boot_q || soft_rst_w);
      if (soft_rst_w) boot_q <= 1'b1;
      else if (boot_go_w) boot_q <= 1'b0;
      if (soft_rst_w) pend_rst_q <= 1'b0;
      else if (resp_k == HSC_RSP_HELP) pend_rst_q <= 1'b1;
      if (resp_go_w) begin
        buf_q <= {line_w[183:0], 8'h00};
        tx_char <= line_w[191:184];
        tx_valid <= 1'b1;
        left_q <= len_w - 5'h01;
        resp_active_q <= 1'b1;
      end else if (tx_valid && tx_ready) begin
        if (left_q != 5'h00) begin
          tx_char <= buf_q[191:184];
          buf_q <= {buf_q[183:0], 8'h00};
          left_q <= left_q - 5'h01;
        end else begin
          tx_valid <= 1'b0;
          resp_active_q <= 1'b0;
        end
      end
    end
  end

  // output stage
  wire use_off_w = !(mode_q == 3'h1 || mode_q == 3'h5 || mode_q == 3'h6);
  wire [23:0] tune_d = sweep_w ? sweep_freq : freq_q + (use_off_w ? {16'h0000, offset_q} : 24'h000000);
  always_ff @(posedge clock) begin
    if (rst) begin
      tune_word <= `HSC_RST_FREQ;
      carrier_on <= 1'b0;
      sweep_sync <= 1'b0;
    end else begin
      tune_word <= tune_d;
      carrier_on <= key_on_q;
      sweep_sync <= sweep_sync_w;
    end
  end

  hsc_sweep #(.UNIT_CYC(DWELL_UNIT_CYC)) u_sweep (
    .clock(clock),
    .rst(rst),
    .en(sweep_w),
    .base(freq_q),
    .step(step_q),
    .dwell(dwell_q),
    .width(width_q),
    .freq_o(sweep_freq),
    .sync_o(sweep_sync_w)
  );
  hsc_symclk u_symclk (
    .clock(clock),
    .rst(rst),
    .sym_pin(sym_clk_pin),
    .periods(key_q),
    .tick_o(sym_tick)
  );

  // apb slave, one wait state
  wire acc_w = psel && penable && !pready;
  wire wr_w = acc_w && pwrite;
  logic [31:0] rd_w;
  logic hit_w;
  always_comb begin
    hit_w = 1'b1;
    rd_w = 32'h00000000;
    if (paddr == `HSC_ADDR_CTRL) rd_w = {29'h0, mode_q};
    else if (paddr == `HSC_ADDR_STATUS)
      rd_w = {21'h0, script_len_q, st_q == HSC_LOAD, resp_active_q, sweep_w, key_on_q};
    else if (paddr == `HSC_ADDR_FREQ) rd_w = {8'h00, freq_q};
    else if (paddr == `HSC_ADDR_OFFSET) rd_w = {24'h0, offset_q};
    else if (paddr == `HSC_ADDR_KEY) rd_w = {16'h0, key_q};
    else if (paddr == `HSC_ADDR_WIDTH) rd_w = {24'h0, width_q};
    else if (paddr == `HSC_ADDR_DWELL) rd_w = {24'h0, dwell_q};
    else if (paddr == `HSC_ADDR_STEP) rd_w = {16'h0, step_q};
    else if (paddr == `HSC_ADDR_SPTR) rd_w = {25'h0, sptr_q};
    else if (paddr == `HSC_ADDR_SDATA) rd_w = (sptr_q < 7'(SCRIPT_MAX)) ? {24'h0, script_mem[sptr_q]} : 32'h0;
    else hit_w = 1'b0;
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      mode_q <= `HSC_RST_CTRL;
      sptr_q <= 7'h00;
    end else begin
      pready <= acc_w;
      pslverr <= acc_w && !hit_w;
      prdata <= (acc_w && !pwrite) ? rd_w : 32'h00000000;
      if (wr_w && paddr == `HSC_ADDR_CTRL) mode_q <= pwdata[2:0];
      if (wr_w && paddr == `HSC_ADDR_SPTR) sptr_q <= pwdata[6:0];
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (rst || soft_rst_w);

  bad_char_a: assert property (
    take_w && st_q == HSC_IDLE && rx_char != `HSC_CH_LF && !known(uc_w)
    |=> tx_valid && tx_char == `HSC_CH_QM && st_q == HSC_IDLE)
    else $error("unknown character did not answer with question mark");
  silent_key_a: assert property (
    take_w && st_q == HSC_IDLE && (uc_w == 8'h54 || uc_w == 8'h58) |=> !tx_valid && !resp_active_q)
    else $error("key command produced a response");
  key_state_a: assert property (
    take_w && st_q == HSC_IDLE && uc_w == 8'h54 |=> key_on_q && $stable(freq_q) ##1 carrier_on)
    else $error("key-down did not switch carrier on");
  tune_load_a: assert property (
    take_w && st_q == HSC_ARGS && cmd_q == 8'h46 && hex_w && got_q == 3'h5
    |=> freq_q == $past(arg_next_w))
    else $error("tune value not loaded on sixth digit");
  abandon_a: assert property (
    take_w && st_q == HSC_ARGS && !hex_w && rx_char != `HSC_CH_LF
    |=> $stable(freq_q) && $stable(offset_q) && $stable(key_q) && $stable(width_q) && st_q == HSC_IDLE)
    else $error("abandoned command changed parameters");
  offset_set_a: assert property (
    exec && cmd_x_w == 8'h41 && !sweep_w |=> offset_q == $past(arg_next_w[7:0]) && $stable(dwell_q))
    else $error("offset not replaced");
  dwell_set_a: assert property (
    exec && cmd_x_w == 8'h41 && sweep_w |=> dwell_q == $past(arg_next_w[7:0]) && $stable(offset_q))
    else $error("sweep dwell not set by offset command");
  span_one_a: assert property (
    exec && cmd_x_w == 8'h57 && arg_next_w[7:0] == 8'h01 |=> $stable(width_q))
    else $error("span 01 changed sweep width");
  arg_limit_a: assert property (got_q <= 3'(`HSC_MAX_ARGS))
    else $error("argument count above six");
  script_cap_a: assert property (wr_cnt_q <= 7'(SCRIPT_MAX))
    else $error("script pointer beyond capacity");
endmodule

// ### testbench/hsc_host_model.sv
`timescale 1ns/1ps
module hsc_host_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic slow,
  output logic rx_valid,
  output logic [7:0] rx_char,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_char,
  output logic tx_ready
);
  logic [7:0] got[$];
  initial begin
    rx_valid = 1'b0;
    rx_char = 8'h00;
    tx_ready = 1'b1;
  end
  // stalls every other cycle when slow
  always @(posedge clock) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (!rst && tx_valid && tx_ready) got.push_back(tx_char);
  end
  // one character per handshake, held until taken
  task automatic send(input byte c);
    rx_valid <= 1'b1;
    rx_char <= c;
    do @(posedge clock); while (rx_ready !== 1'b1);
    rx_valid <= 1'b0;
    rx_char <= ~c;
    @(posedge clock);
  endtask
  task automatic send_str(input string s);
    foreach (s[i]) send(s[i]);
  endtask
endmodule

// ### testbench/hex_serial_command_parser_tb_top.sv
`timescale 1ns/1ps
`include "hsc_consts.svh"
module hex_serial_command_parser_tb_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic sym_clk_pin = 1'b0;
  logic slow = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, rx_valid, rx_ready, tx_valid, tx_ready, sym_tick, carrier_on, sweep_sync;
  logic [7:0] rx_char, tx_char;
  logic [23:0] tune_word;
  int n_mismatch = 0;
  int checks = 0;
  int pc = 0;
  int ticks = 0;
  always #5 clock = ~clock;
  hsc_top #(.DWELL_UNIT_CYC(4), .SCRIPT_MAX(120)) u_dut (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_char(rx_char), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_char(tx_char), .tx_ready(tx_ready), .sym_clk_pin(sym_clk_pin), .sym_tick(sym_tick),
    .tune_word(tune_word), .carrier_on(carrier_on), .sweep_sync(sweep_sync));
  hsc_host_model u_host (.clock(clock), .rst(rst), .slow(slow), .rx_valid(rx_valid), .rx_char(rx_char),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_char(tx_char), .tx_ready(tx_ready));
  // symbol clock pin, period 40 cycles
  always @(posedge clock) begin
    pc <= pc + 1;
    if (pc % 20 == 19) sym_clk_pin <= ~sym_clk_pin;
    if (sym_tick === 1'b1) ticks <= ticks + 1;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp_val(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_str(input string e, input bit full);
    cmp_val(u_host.got.size(), e.len());
    if (full) foreach (e[i]) if (i < u_host.got.size()) cmp_val(u_host.got[i], e[i]);
    u_host.got.delete();
  endtask
  task automatic cmd(input string s, input string e, input bit full);
    int k = 0;
    u_host.got.delete();
    u_host.send_str(s);
    while (u_host.got.size() < e.len() && k < 3000) begin
      @(posedge clock);
      k++;
    end
    repeat (40) @(posedge clock);
    cmp_str(e, full);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    cmp_val(r & m, x);
  endtask
  task automatic count_ticks(input int x);
    int t0;
    @(posedge sym_clk_pin);
    repeat (8) @(posedge clock);
    t0 = ticks;
    repeat (8) @(posedge sym_clk_pin);
    repeat (8) @(posedge clock);
    cmp_val(ticks - t0, x);
  endtask
  task automatic t_basic;
    cmd("", "HSC OK\r\n", 1'b1);
    cmd("F123456", "F\r\n", 1'b1);
    cmp_val(tune_word, 24'h123456);
    rdm(`HSC_ADDR_FREQ, 32'hFFFFFFFF, 32'h123456);
    cmd("A05", "A\r\n", 1'b1);
    cmp_val(tune_word, 24'h12345B);
    cmd("a10", "A\r\n", 1'b0);
    cmp_val(tune_word, 24'h123466);
    cmd("A7\r", "?\r\n", 1'b1);
    cmd("F0g", "?\r\n", 1'b1);
    cmd("Z", "?\r\n", 1'b1);
    cmd("\n", "", 1'b1);
    cmp_val(tune_word, 24'h123466);
    $display("test basic done");
  endtask
  task automatic t_key;
    cmd("T", "", 1'b1);
    cmp_val(carrier_on, 1'b1);
    cmp_val(tune_word, 24'h123466);
    cmd("X", "", 1'b1);
    cmp_val(carrier_on, 1'b0);
    cmd("K0001", "K\r\n", 1'b1);
    rdm(`HSC_ADDR_KEY, 32'hFFFFFFFF, 32'h1);
    count_ticks(4);
    cmd("K0003", "K\r\n", 1'b1);
    count_ticks(2);
    cmd("T", "", 1'b1);
    cmd("R", "A10 K0003 W00 F123456\r\n", 1'b1);
    cmd("X", "", 1'b1);
    $display("test key done");
  endtask
  task automatic t_sweep;
    int k = 0;
    cmd("W02", "W\r\n", 1'b1);
    cmd("A03", "A\r\n", 1'b1);
    cmd("K0010", "K\r\n", 1'b1);
    rdm(`HSC_ADDR_DWELL, 32'hFF, 32'h3);
    rdm(`HSC_ADDR_OFFSET, 32'hFF, 32'h10);
    rdm(`HSC_ADDR_STEP, 32'hFFFF, 32'h10);
    while (sweep_sync !== 1'b1 && k < 500) begin
      @(posedge clock);
      k++;
    end
    cmp_val(k < 500, 1'b1);
    @(posedge clock);
    cmp_val(tune_word, 24'h123456);
    k = 0;
    while (tune_word !== 24'h123466 && k < 100) begin
      @(posedge clock);
      k++;
    end
    cmp_val(tune_word, 24'h123466);
    cmd("W01", "W\r\n", 1'b1);
    rdm(`HSC_ADDR_WIDTH, 32'hFF, 32'h2);
    cmd("W00", "W\r\n", 1'b1);
    rdm(`HSC_ADDR_STATUS, 32'h2, 32'h0);
    cmp_val(tune_word, 24'h123466);
    $display("test sweep done");
  endtask
  task automatic t_mode;
    logic [31:0] r;
    logic e;
    int modes[3] = '{1, 5, 6};
    foreach (modes[i]) begin
      wr(`HSC_ADDR_CTRL, modes[i]);
      repeat (4) @(posedge clock);
      cmp_val(tune_word, 24'h123456);
    end
    wr(`HSC_ADDR_CTRL, 32'h0);
    rdm(`HSC_ADDR_CTRL, 32'h7, 32'h0);
    apb(1'b0, 8'h40, 32'h0, r, e);
    cmp_val({r[30:0], e}, 32'h1);
    $display("test mode done");
  endtask
  task automatic t_script;
    cmd("B", "B\r\n", 1'b1);
    cmd("12 34\rFF~", "HSC OK\r\n", 1'b1);
    rdm(`HSC_ADDR_STATUS, 32'h7F0, 32'h30);
    wr(`HSC_ADDR_SPTR, 32'h1);
    rdm(`HSC_ADDR_SDATA, 32'hFF, 32'h34);
    rdm(`HSC_ADDR_FREQ, 32'hFFFFFF, 32'h0);
    cmd("B", "B\r\n", 1'b1);
    cmd("1\n", "?\r\n", 1'b1);
    rdm(`HSC_ADDR_STATUS, 32'h7F8, 32'h30);
    cmd("F000010", "F\r\n", 1'b1);
    slow <= 1'b1;
    cmd("H", "A2 B F6 H K4 R T W2 X\r\nHSC OK\r\n", 1'b1);
    slow <= 1'b0;
    cmp_val(tune_word, 24'h0);
    $display("test script done");
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    t_basic;
    t_key;
    t_sweep;
    t_mode;
    t_script;
    tally_and_finish;
  end
  initial begin
    repeat (60000) @(posedge clock);
    n_mismatch++;
    tally_and_finish;
  end
endmodule
